// file: src/tmr_defines.svh
// Register indices, bit positions, widths and the reset value of the timer interrupt/status block
// Overview of operation
// RULE1: Each interrupt request needs its enable bit, its flag and global enable; the irq output needs only enable and flag.
// RULE2: Compare-B match sets the flag in bit 2.
// RULE3: Compare-A match sets the flag in bit 1.
// RULE4: Overflow sets flag; phase-correct modes set it at direction reversal at bottom.
// RULE5: Executing a flag's interrupt vector clears that flag.
// RULE6: Writing one clears a flag; writing zero leaves it.
// RULE7: External clock buffer on when bit 6 and async selected; crystal only when clear.
// RULE8: Software sets external clock enable before selecting async clocking.
// RULE9: Bit 5 low clocks timer from I/O clock, high from oscillator pin.
// RULE10: Software rewrites timer registers after changing async select.
// RULE11: Async writes set per-register busy flags, cleared when transfer completes.
// RULE12: Software never writes a timer register while its busy flag is set.
// RULE13: Counter reads return live value; compare and control reads return staging copies.
// RULE14: Writing one to prescaler reset bit resets prescaler; hardware then clears it.
// RULE15: In async mode the bit stays set until the timer domain confirms reset.
// RULE16: Hold mode bit 7 stops hardware clearing, keeping the prescaler in reset.
// RULE17: Async status bit 7 and unused mask bits always read zero.
// RULE18: Events and busy completions from timer domain pass synchronisers before use.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Word indices; byte address is four times the index
`define TMR_IDX_GEN_CTRL 10'h043
`define TMR_IDX_IRQ_MASK 10'h070
`define TMR_IDX_IRQ_FLAGS 10'h037
`define TMR_IDX_ASYNC_STAT 10'h0B6
`define TMR_IDX_CTRL_A 10'h0B0
`define TMR_IDX_CTRL_B 10'h0B1
`define TMR_IDX_COUNT 10'h0B2
`define TMR_IDX_CMP_A 10'h0B3
`define TMR_IDX_CMP_B 10'h0B4

// Flag and enable positions
`define TMR_BIT_CMPB 2
`define TMR_BIT_CMPA 1
`define TMR_BIT_OVF 0
`define TMR_IRQ_W 3

// Async status positions
`define TMR_BIT_EXT_CLOCK_INPUT_ENABLE 6
`define TMR_BIT_AS2 5
`define TMR_BUSY_COUNT 4
`define TMR_BUSY_CMPA 3
`define TMR_BUSY_CMPB 2
`define TMR_BUSY_CTRLA 1
`define TMR_BUSY_CTRLB 0
`define TMR_BUSY_W 5

// General control positions
`define TMR_BIT_TSM 7
`define TMR_BIT_ASYNC_PRESCALER_RESET 1
`define TMR_BIT_SYNC_PRESCALER_RESET 0

// Reset value of every register
`define TMR_RST_BYTE 8'h00

// Waveform bits of control A that select phase-correct counting
`define TMR_WGM_PHASE 2'b01

// Synchroniser lane positions
`define TMR_SY_CMPB 0
`define TMR_SY_CMPA 1
`define TMR_SY_OVF 2
`define TMR_SY_BOT 3
`define TMR_SY_PRST 4
`define TMR_SY_UB 5
`define TMR_SY_W 10

`endif

// file: src/tmr_pkg.sv
// Types shared by the timer interrupt/status block
package tmr_pkg;
  `include "tmr_defines.svh"

  typedef enum logic [0:0] {PR_IDLE, PR_WAIT} tmr_prst_e;

  typedef struct packed {
    logic [`TMR_SY_W-1:0] sy1;
    logic [`TMR_SY_W-1:0] sy2;
    logic [`TMR_SY_W-1:0] syPrev;
    logic [`TMR_IRQ_W-1:0] irqFlags;
    logic [`TMR_IRQ_W-1:0] irqMask;
    logic extClk;
    logic asyncSel;
    logic [`TMR_BUSY_W-1:0] busy;
    logic [`TMR_BUSY_W-1:0] loadTgl;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] cmpA;
    logic [7:0] cmpB;
    logic [7:0] cntWr;
    logic holdMode;
    logic psrAsync;
    logic sync_prescaler_reset;
    logic prTgl;
    tmr_prst_e prState;
    logic [7:0] rdData;
  } tmr_state_s;
endpackage

// file: src/tmr_irq_async_status.sv
// Interrupt mask/flags, async clock status and prescaler reset of the third timer
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tmr_irq_async_status (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic cpuIrqEnable,
  input wire logic [`TMR_IRQ_W-1:0] vectorAck,
  output logic [`TMR_IRQ_W-1:0] irqReq,
  output logic irq,
  // Toggles and the live count from the timer clock domain
  input wire logic cmpBMatchTgl,
  input wire logic cmpAMatchTgl,
  input wire logic overflowTgl,
  input wire logic bottomTgl,
  input wire logic prescalerAckTgl,
  input wire logic [`TMR_BUSY_W-1:0] updateAckTgl,
  input wire logic [7:0] timerCountIn,
  // Towards the timer
  output logic [7:0] timerControlA,
  output logic [7:0] timerControlB,
  output logic [7:0] compareAValue,
  output logic [7:0] compareBValue,
  output logic [7:0] counterWriteValue,
  output logic [`TMR_BUSY_W-1:0] regLoadTgl,
  output logic asyncClockSelect,
  output logic extClockInputEnable,
  output logic xtalOscEnable,
  output logic asyncPrescalerReset,
  output logic prescalerResetTgl,
  output logic syncPrescalerReset,
  output logic timerSyncHoldMode
);
  import tmr_pkg::*;

  tmr_state_s q;
  tmr_state_s d;

  logic [9:0] wordIdx;
  logic aligned;
  logic mapped;
  logic setupRd;
  logic wrEn;
  logic [7:0] wByte;
  logic [`TMR_SY_W-1:0] syIn;
  logic [`TMR_SY_W-1:0] syEdge;
  logic [`TMR_IRQ_W-1:0] evtSet;
  logic phaseCorrect;
  logic [`TMR_BUSY_W-1:0] regWr;
  logic [7:0] rdMux;

  // Address decode shared by read and write paths
  assign wordIdx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned && ((wordIdx == `TMR_IDX_GEN_CTRL) || (wordIdx == `TMR_IDX_IRQ_MASK) ||
                  (wordIdx == `TMR_IDX_IRQ_FLAGS) || (wordIdx == `TMR_IDX_ASYNC_STAT) ||
                  (wordIdx == `TMR_IDX_CTRL_A) || (wordIdx == `TMR_IDX_CTRL_B) ||
                  (wordIdx == `TMR_IDX_COUNT) || (wordIdx == `TMR_IDX_CMP_A) ||
                  (wordIdx == `TMR_IDX_CMP_B));

  // Zero-wait answer; frozen clock enable stretches the access
  assign pready = psel && penable && ce;
  assign pslverr = pready && !mapped;
  assign setupRd = psel && !penable && !pwrite;
  // Only byte lane 0 carries register data
  assign wrEn = pready && pwrite && mapped && pstrb[0];
  assign wByte = pwdata[7:0];

  // Event lanes from the timer domain, all toggles
  assign syIn = {updateAckTgl, prescalerAckTgl, bottomTgl, overflowTgl, cmpAMatchTgl, cmpBMatchTgl};
  // Edge found on second and third stage only, first stage feeds nothing else
  assign syEdge = q.sy2 ^ q.syPrev; // RULE18

  // Phase-correct modes report overflow at the bottom turn instead of wrap
  assign phaseCorrect = (q.ctrlA[1:0] == `TMR_WGM_PHASE);
  always_comb begin
    evtSet = '0;
    evtSet[`TMR_BIT_CMPB] = syEdge[`TMR_SY_CMPB]; // RULE2
    evtSet[`TMR_BIT_CMPA] = syEdge[`TMR_SY_CMPA]; // RULE3
    evtSet[`TMR_BIT_OVF] = phaseCorrect ? syEdge[`TMR_SY_BOT] : syEdge[`TMR_SY_OVF]; // RULE4
  end

  // Writes to the five staged timer registers, in busy-bit order
  always_comb begin
    regWr = '0;
    if (wrEn) begin
      if (wordIdx == `TMR_IDX_COUNT) begin
        regWr[`TMR_BUSY_COUNT] = 1'b1;
      end else if (wordIdx == `TMR_IDX_CMP_A) begin
        regWr[`TMR_BUSY_CMPA] = 1'b1;
      end else if (wordIdx == `TMR_IDX_CMP_B) begin
        regWr[`TMR_BUSY_CMPB] = 1'b1;
      end else if (wordIdx == `TMR_IDX_CTRL_A) begin
        regWr[`TMR_BUSY_CTRLA] = 1'b1;
      end else if (wordIdx == `TMR_IDX_CTRL_B) begin
        regWr[`TMR_BUSY_CTRLB] = 1'b1;
      end
    end
  end

  // Read multiplexer, sampled in the setup cycle
  always_comb begin
    rdMux = `TMR_RST_BYTE;
    if (wordIdx == `TMR_IDX_GEN_CTRL) begin
      rdMux[`TMR_BIT_TSM] = q.holdMode;
      rdMux[`TMR_BIT_ASYNC_PRESCALER_RESET] = q.psrAsync;
      rdMux[`TMR_BIT_SYNC_PRESCALER_RESET] = q.sync_prescaler_reset;
    end else if (wordIdx == `TMR_IDX_IRQ_MASK) begin
      rdMux[`TMR_IRQ_W-1:0] = q.irqMask; // RULE17
    end else if (wordIdx == `TMR_IDX_IRQ_FLAGS) begin
      rdMux[`TMR_IRQ_W-1:0] = q.irqFlags;
    end else if (wordIdx == `TMR_IDX_ASYNC_STAT) begin
      rdMux[`TMR_BIT_EXT_CLOCK_INPUT_ENABLE] = q.extClk; // RULE17
      rdMux[`TMR_BIT_AS2] = q.asyncSel;
      rdMux[`TMR_BUSY_W-1:0] = q.busy;
    end else if (wordIdx == `TMR_IDX_COUNT) begin
      rdMux = timerCountIn; // RULE13
    end else if (wordIdx == `TMR_IDX_CMP_A) begin
      rdMux = q.cmpA; // RULE13
    end else if (wordIdx == `TMR_IDX_CMP_B) begin
      rdMux = q.cmpB;
    end else if (wordIdx == `TMR_IDX_CTRL_A) begin
      rdMux = q.ctrlA;
    end else if (wordIdx == `TMR_IDX_CTRL_B) begin
      rdMux = q.ctrlB;
    end
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.sy1 = syIn;
    d.sy2 = q.sy1;
    d.syPrev = q.sy2;

    // Read data held from setup to access
    if (setupRd) begin
      d.rdData = aligned ? rdMux : `TMR_RST_BYTE;
    end

    // Flags: set wins over vector clear and write-one clear
    d.irqFlags = q.irqFlags & ~vectorAck; // RULE5
    if (wrEn && (wordIdx == `TMR_IDX_IRQ_FLAGS)) begin
      d.irqFlags = d.irqFlags & ~wByte[`TMR_IRQ_W-1:0]; // RULE6
    end
    d.irqFlags = d.irqFlags | evtSet;

    if (wrEn && (wordIdx == `TMR_IDX_IRQ_MASK)) begin
      d.irqMask = wByte[`TMR_IRQ_W-1:0];
    end

    // Clock source selection
    if (wrEn && (wordIdx == `TMR_IDX_ASYNC_STAT)) begin
      d.extClk = wByte[`TMR_BIT_EXT_CLOCK_INPUT_ENABLE];
      d.asyncSel = wByte[`TMR_BIT_AS2]; // RULE9
    end

    // Staging registers and load toggles towards the timer
    if (regWr[`TMR_BUSY_COUNT]) begin
      d.cntWr = wByte;
    end
    if (regWr[`TMR_BUSY_CMPA]) begin
      d.cmpA = wByte;
    end
    if (regWr[`TMR_BUSY_CMPB]) begin
      d.cmpB = wByte;
    end
    if (regWr[`TMR_BUSY_CTRLA]) begin
      d.ctrlA = wByte;
    end
    if (regWr[`TMR_BUSY_CTRLB]) begin
      d.ctrlB = wByte;
    end
    d.loadTgl = q.loadTgl ^ regWr;

    // Busy only in async mode; a fresh write beats a late acknowledge
    d.busy = q.busy & ~syEdge[`TMR_SY_UB +: `TMR_BUSY_W]; // RULE11
    if (q.asyncSel) begin
      d.busy = d.busy | regWr; // RULE11
    end

    // Prescaler control: software writes, hardware clears
    if (wrEn && (wordIdx == `TMR_IDX_GEN_CTRL)) begin
      d.holdMode = wByte[`TMR_BIT_TSM];
      d.sync_prescaler_reset = wByte[`TMR_BIT_SYNC_PRESCALER_RESET];
      d.psrAsync = wByte[`TMR_BIT_ASYNC_PRESCALER_RESET]; // RULE14
    end else begin
      // Synchronous prescaler bit clears next cycle unless held
      if (q.sync_prescaler_reset && !q.holdMode) begin
        d.sync_prescaler_reset = 1'b0; // RULE16
      end
    end

    case (q.prState)
      PR_IDLE: begin
        if (wrEn && (wordIdx == `TMR_IDX_GEN_CTRL) && wByte[`TMR_BIT_ASYNC_PRESCALER_RESET] && q.asyncSel) begin
          d.prTgl = ~q.prTgl;
          d.prState = PR_WAIT; // RULE15
        end else if (q.psrAsync && !q.holdMode && !(wrEn && (wordIdx == `TMR_IDX_GEN_CTRL))) begin
          d.psrAsync = 1'b0; // RULE14 RULE16
        end
      end
      PR_WAIT: begin
        // Bit held until the timer domain confirms the reset
        if (syEdge[`TMR_SY_PRST]) begin
          d.prState = PR_IDLE;
          if (!q.holdMode) begin
            d.psrAsync = 1'b0; // RULE15 RULE16
          end
        end
      end
      default: begin
        d.prState = PR_IDLE;
      end
    endcase
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // Requests irqReq gated by enable, flag and global enable; irq by enable and flag only
  assign irqReq = q.irqFlags & q.irqMask & {`TMR_IRQ_W{cpuIrqEnable}}; // RULE1
  assign irq = |(q.irqFlags & q.irqMask);

  // Outputs, all from the state register
  assign prdata = {24'h000000, q.rdData};
  assign timerControlA = q.ctrlA;
  assign timerControlB = q.ctrlB;
  assign compareAValue = q.cmpA;
  assign compareBValue = q.cmpB;
  assign counterWriteValue = q.cntWr;
  assign regLoadTgl = q.loadTgl;
  assign asyncClockSelect = q.asyncSel; // RULE9
  // Crystal stops whenever an external clock is expected
  assign extClockInputEnable = q.extClk && q.asyncSel; // RULE7
  assign xtalOscEnable = !q.extClk; // RULE7
  assign asyncPrescalerReset = q.psrAsync; // RULE14
  assign prescalerResetTgl = q.prTgl;
  assign syncPrescalerReset = q.sync_prescaler_reset;
  assign timerSyncHoldMode = q.holdMode;
endmodule // tmr_irq_async_status

// file: verif/tmr_irq_asserts.sv
// Concurrent checks on the ports of the timer interrupt/status block
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tmr_irq_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic cpuIrqEnable,
  input wire logic [`TMR_IRQ_W-1:0] vectorAck,
  input wire logic [`TMR_IRQ_W-1:0] irqReq,
  input wire logic irq,
  input wire logic cmpAMatchTgl,
  input wire logic asyncClockSelect,
  input wire logic extClockInputEnable,
  input wire logic xtalOscEnable,
  input wire logic asyncPrescalerReset,
  input wire logic timerSyncHoldMode
);
  // Toggle history, so clears are only judged when no set can race them
  // Frozen with the block's clock enable, so it tracks the synchroniser
  logic [3:0] tA_r;
  always_ff @(posedge core_clk) begin
    if (ce) begin
      tA_r <= {tA_r[2:0], cmpAMatchTgl};
    end
  end
  // Decoded bus access
  wire acc = psel && penable && pready;
  wire wrAcc = acc && pwrite;
  wire [9:0] idx = paddr[11:2];
  wire quietA = tA_r[2:0] == {3{cmpAMatchTgl}};
  wire genWr = wrAcc && idx == `TMR_IDX_GEN_CTRL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Request of an async prescaler reset
  sequence sPsrWr;
    genWr && pwdata[1];
  endsequence
  a_irq_gate: assert property (cpuIrqEnable |-> irq == (irqReq != 3'h0))
    else $error("irq and request disagree");
  a_req_gie: assert property (irqReq != 3'h0 |-> cpuIrqEnable && irq)
    else $error("request without global enable");
  a_ext_xtal: assert property (extClockInputEnable |-> asyncClockSelect && !xtalOscEnable)
    else $error("ext clock buffer misgated");
  a_set_cmpa: assert property ($rose(irqReq[1]) |-> tA_r[2] != tA_r[3] ||
    $past(wrAcc && idx == `TMR_IDX_IRQ_MASK) || $rose(cpuIrqEnable))
    else $error("compare A request without cause");
  a_ack_clear: assert property (vectorAck[1] && quietA |=> !irqReq[1])
    else $error("vector did not clear flag");
  a_w1c_clear: assert property (wrAcc && idx == `TMR_IDX_IRQ_FLAGS && pwdata[1]
    && quietA |=> !irqReq[1]) else $error("write one did not clear");
  a_rd_zero: assert property (acc && !pwrite && (idx == `TMR_IDX_ASYNC_STAT ||
    idx == `TMR_IDX_IRQ_MASK) |-> prdata[31:7] == 25'h0 &&
    (idx != `TMR_IDX_IRQ_MASK || prdata[6:3] == 4'h0)) else $error("unused bits set");
  a_psr_pulse: assert property (sPsrWr and !pwdata[7] && !asyncClockSelect
    |=> asyncPrescalerReset ##1 !asyncPrescalerReset) else $error("psr not a pulse");
  a_psr_hold: assert property (timerSyncHoldMode && asyncPrescalerReset && !genWr
    |=> asyncPrescalerReset) else $error("psr cleared in hold");
  a_psr_async: assert property (sPsrWr and asyncClockSelect
    |=> asyncPrescalerReset [*3]) else $error("async psr cleared early");
endmodule // tmr_irq_asserts

// file: verif/test_tmr_irq_async_status.sv
// Self-checking bench for the timer interrupt/status block
`timescale 1ns/10ps
`include "tmr_defines.svh"
module test_tmr_irq_async_status;
  logic core_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic gie = 1'h0, ce = 1'h1, se, rse;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdv;
  logic [2:0] vAck = 3'h0;
  logic [4:0] ev = 5'h00, uAck = 5'h00;
  logic [7:0] cnt = 8'h00;
  wire [31:0] prdata;
  wire [2:0] irqReq;
  wire [7:0] ctlA, ctlB, cmpAv, cmpBv, cntW;
  wire [4:0] ldT;
  wire pready, irq, psrA, psrS, psrT, hold, extEn, xtal, aSel;
  int errTotal = 0, nChecks = 0;
  always #5 core_clk = ~core_clk;
  // Byte strobes tied on; everything else is driven
  tmr_irq_async_status tmr_irq_async_status_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(se), .cpuIrqEnable(gie),
    .vectorAck(vAck), .irqReq(irqReq), .irq(irq), .cmpBMatchTgl(ev[0]),
    .cmpAMatchTgl(ev[1]), .overflowTgl(ev[2]), .bottomTgl(ev[3]), .prescalerAckTgl(ev[4]),
    .updateAckTgl(uAck), .timerCountIn(cnt), .timerControlA(ctlA), .timerControlB(ctlB),
    .compareAValue(cmpAv), .compareBValue(cmpBv), .counterWriteValue(cntW), .regLoadTgl(ldT),
    .asyncClockSelect(aSel), .extClockInputEnable(extEn), .xtalOscEnable(xtal),
    .asyncPrescalerReset(psrA), .prescalerResetTgl(psrT), .syncPrescalerReset(psrS),
    .timerSyncHoldMode(hold));
  task stopTest;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; waits for pready, only the watchdog bounds the wait
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite} <= {1'h1, 1'h0, w};
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    // Error response only stands during the access
    rdv = prdata;
    rse = se;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task rdc(input logic [9:0] i, input logic [7:0] e, input string nm);
    apb(1'h0, i, 8'h00);
    chk(nm, rdv, {24'h0, e});
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task tgl(input int i);
    @(posedge core_clk);
    ev[i] <= ~ev[i];
  endtask
  task tReset;
    chk("xtal", xtal, 1'h1);
    rdc(`TMR_IDX_GEN_CTRL, 8'h00, "gen");
    rdc(`TMR_IDX_IRQ_MASK, 8'h00, "mask");
    rdc(`TMR_IDX_ASYNC_STAT, 8'h00, "async");
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h00, "flags");
    chk("noerr", rse, 1'h0);
    rdc(10'h3FF, 8'h00, "unmapped");
    chk("slverr", rse, 1'h1);
  endtask
  task tFlags;
    apb(1'h1, `TMR_IDX_IRQ_MASK, 8'hFF);
    rdc(`TMR_IDX_IRQ_MASK, 8'h07, "mask");
    @(posedge core_clk);
    gie <= 1'h1;
    for (int i = 0; i < 3; i++) tgl(i);
    tick(4);
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h07, "set");
    chk("req", irqReq, 3'h7);
    @(posedge core_clk);
    gie <= 1'h0;
    tick(1);
    chk("gie", {irq, irqReq}, 4'h8);
    // Global enable back on so the clears show on the requests
    @(posedge core_clk);
    gie <= 1'h1;
    apb(1'h1, `TMR_IDX_IRQ_FLAGS, 8'h00);
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h07, "w0");
    apb(1'h1, `TMR_IDX_IRQ_FLAGS, 8'h02);
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h05, "w1");
    chk("w1req", irqReq, 3'h5);
    tgl(1);
    tick(4);
    @(posedge core_clk);
    vAck <= 3'h6;
    @(posedge core_clk);
    vAck <= 3'h0;
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h01, "vec");
    apb(1'h1, `TMR_IDX_IRQ_MASK, 8'h06);
    chk("masked", irq, 1'h0);
    apb(1'h1, `TMR_IDX_IRQ_FLAGS, 8'h07);
  endtask
  // Phase-correct counting swaps overflow for bottom events
  task tPhase;
    apb(1'h1, `TMR_IDX_CTRL_A, 8'h01);
    tgl(2);
    tick(4);
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h00, "ovf");
    tgl(3);
    tick(4);
    rdc(`TMR_IDX_IRQ_FLAGS, 8'h01, "bot");
    apb(1'h1, `TMR_IDX_IRQ_FLAGS, 8'h01);
    apb(1'h1, `TMR_IDX_CTRL_A, 8'h00);
  endtask
  task tAsync;
    apb(1'h1, `TMR_IDX_ASYNC_STAT, 8'h40);
    chk("ext", extEn, 1'h0);
    apb(1'h1, `TMR_IDX_ASYNC_STAT, 8'h60);
    chk("clk", {extEn, xtal, aSel}, 3'h5);
    apb(1'h1, `TMR_IDX_CMP_A, 8'h5A);
    rdc(`TMR_IDX_ASYNC_STAT, 8'h68, "busy");
    apb(1'h1, `TMR_IDX_CMP_B, 8'hA5);
    apb(1'h1, `TMR_IDX_CTRL_B, 8'hC3);
    apb(1'h1, `TMR_IDX_COUNT, 8'h77);
    apb(1'h1, `TMR_IDX_CTRL_A, 8'h00);
    rdc(`TMR_IDX_ASYNC_STAT, 8'h7F, "allbusy");
    rdc(`TMR_IDX_CTRL_B, 8'hC3, "ctrlb");
    chk("stage", {cmpAv, cmpBv, ctlB, cntW}, 32'h5AA5C377);
    chk("load", {ldT, ctlA}, 13'h1F00);
    rdc(`TMR_IDX_CMP_A, 8'h5A, "cmpa");
    @(posedge core_clk);
    cnt <= 8'h3C;
    rdc(`TMR_IDX_COUNT, 8'h3C, "count");
    @(posedge core_clk);
    uAck[3] <= 1'h1;
    tick(4);
    rdc(`TMR_IDX_ASYNC_STAT, 8'h77, "ack");
    @(posedge core_clk);
    uAck <= 5'h1F;
    tick(4);
    rdc(`TMR_IDX_ASYNC_STAT, 8'h60, "done");
    apb(1'h1, `TMR_IDX_GEN_CTRL, 8'h02);
    chk("ptgl", psrT, 1'h1);
    tick(3);
    chk("psr", psrA, 1'h1);
    tgl(4);
    tick(4);
    chk("psr", psrA, 1'h0);
    apb(1'h1, `TMR_IDX_ASYNC_STAT, 8'h00);
    apb(1'h1, `TMR_IDX_CMP_A, 8'h5A);
    rdc(`TMR_IDX_ASYNC_STAT, 8'h00, "sync");
  endtask
  task tPsr;
    apb(1'h1, `TMR_IDX_GEN_CTRL, 8'h03);
    chk("psr", {psrA, psrS}, 2'h3);
    tick(1);
    chk("psr", {psrA, psrS}, 2'h0);
    apb(1'h1, `TMR_IDX_GEN_CTRL, 8'h83);
    tick(5);
    chk("hold", {psrA, psrS, hold}, 3'h7);
    apb(1'h1, `TMR_IDX_GEN_CTRL, 8'h00);
    chk("hold", {psrA, psrS, hold}, 3'h0);
  endtask
  // Frozen clock enable holds an event in the synchroniser
  task tCe;
    @(posedge core_clk);
    ce <= 1'h0;
    tgl(1);
    tick(6);
    chk("frozen", irqReq, 3'h0);
    @(posedge core_clk);
    ce <= 1'h1;
    tick(4);
    chk("thawed", irqReq, 3'h2);
    apb(1'h1, `TMR_IDX_IRQ_FLAGS, 8'h02);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'h1;
    tReset;
    tFlags;
    tPhase;
    tAsync;
    tPsr;
    tCe;
    stopTest;
  end
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    errTotal++;
    stopTest;
  end
endmodule // test_tmr_irq_async_status
bind tmr_irq_async_status tmr_irq_asserts tmr_irq_asserts_i (.core_clk(core_clk),
  .rst_b(rst_b), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .cpuIrqEnable(cpuIrqEnable),
  .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq), .cmpAMatchTgl(cmpAMatchTgl),
  .asyncClockSelect(asyncClockSelect), .extClockInputEnable(extClockInputEnable),
  .xtalOscEnable(xtalOscEnable), .asyncPrescalerReset(asyncPrescalerReset),
  .timerSyncHoldMode(timerSyncHoldMode));
